// >>> src/spcfg_pkg.sv
package spcfg_pkg;

  // register addresses on the serial port (13-bit address field)
  localparam logic [12:0] SETUP_ADDR = 13'h0000;
  localparam logic [12:0] READBACK_ADDR = 13'h0004;
  localparam logic [12:0] PDSYNC_ADDR = 13'h0230;
  localparam logic [12:0] SPARE_ADDR = 13'h0231;
  localparam logic [12:0] XFER_ADDR = 13'h0232;

  // field positions in serial_port_setup
  localparam int OUTSEL_BIT = 7;
  localparam int LSB_FIRST_BIT = 6;
  localparam int RESTORE_BIT = 5;
  localparam int LONG_INSTR_BIT = 4;
  // field positions in readback_bank_choice and buffer_to_active_transfer
  localparam int BANK_BIT = 0;
  localparam int XFER_BIT = 0;

  // values after reset
  localparam logic [7:0] SETUP_RESET = 8'h18;
  localparam logic [7:0] READBACK_RESET = 8'h00;
  localparam logic [7:0] PDSYNC_RESET = 8'h00;

  // instruction word layout: read flag, byte count, address
  localparam int INSTR_BITS = 16;
  localparam int RW_POS = 15;
  localparam int WCNT_HI = 14;
  localparam int WCNT_LO = 13;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [1:0] WCNT_STREAM = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_INSTR = 4'h2,
    ST_DATA = 4'h4,
    ST_WAIT = 4'h8
  } port_state_t;

endpackage

// >>> src/reg_bank_pair.sv
`timescale 1ns/100ps
`default_nettype none
module reg_bank_pair #(
  parameter int ENTRIES = 1,
  parameter int W = 8,
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter int IDX_W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restore,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic xfer,
  input wire logic [IDX_W-1:0] rd_idx,
  input wire logic rd_active,
  output logic [W-1:0] rd_data,
  output logic [ENTRIES*W-1:0] active_out
);

  logic [ENTRIES*W-1:0] buf_flat;
  logic [W-1:0] rd_data_ff;

  initial begin
    if (ENTRIES < 1 || ENTRIES > (1 << IDX_W) || W != 8) begin
      $error("reg_bank_pair: unsupported ENTRIES, IDX_W or W");
    end
  end

  // each entry keeps a buffered copy and an active copy
  for (genvar g = 0; g < ENTRIES; g++) begin : gen_entry
    logic [W-1:0] buf_ff;
    logic [W-1:0] act_ff;
    // restore holds both copies at default for as long as it stands
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        buf_ff <= RESET_VAL;
      end else if (restore) begin
        buf_ff <= RESET_VAL;
      end else if (wr_en && wr_idx == IDX_W'(g)) begin
        buf_ff <= wr_data;
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        act_ff <= RESET_VAL;
      end else if (restore) begin
        act_ff <= RESET_VAL;
      end else if (xfer) begin
        act_ff <= buf_ff;
      end
    end
    assign buf_flat[g*W +: W] = buf_ff;
    assign active_out[g*W +: W] = act_ff;
  end

  // registered read port, bank chosen by the caller
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= RESET_VAL;
    end else if (rd_active) begin
      rd_data_ff <= active_out[rd_idx*W +: W];
    end else begin
      rd_data_ff <= buf_flat[rd_idx*W +: W];
    end
  end
  assign rd_data = rd_data_ff;

  AST_XFER_COPIES_ALL: assert property (
    @(posedge clk) disable iff (!rst_n)
    xfer && !restore |=> active_out == $past(buf_flat))
    else $error("transfer strobe did not copy buffer into active");

endmodule
`default_nettype wire

// >>> src/serial_port_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_config_regs
  import spcfg_pkg::*;
#(
  parameter int ENTRIES = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic serial_data_out_pin,
  output logic serial_data_out_oe_n,
  output logic restore_active,
  output logic lsb_first_mode,
  output logic [7:0] pdsync_active
);
  import spcfg_pkg::*;

  initial begin
    if (ENTRIES != 1) begin
      $error("serial_port_config_regs: only one buffered register is mapped");
    end
  end

  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic cs_s1_ff, cs_s2_ff;
  logic din_s1_ff, din_s2_ff;
  port_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [15:0] instr_sh_ff;
  logic [7:0] data_sh_ff;
  logic [12:0] addr_ff;
  logic rd_ff, stream_ff, order_lsb_ff;
  logic [1:0] bytes_left_ff;
  logic fetch_ff, fetch_d1_ff;
  logic [7:0] out_sh_ff;
  logic out_bit_ff;
  logic [7:0] setup_ff;
  logic readback_ff;
  logic [15:0] instr_next;
  logic [7:0] byte_next;
  logic sclk_rise, sclk_fall, cs_active;
  logic last_instr, last_bit, more_bytes, wr_now, driving;
  logic restore, xfer_pulse, mem_wr;
  logic [7:0] mem_rd;

  // pins come from the host's domain: two flops before anything looks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end else begin
      sclk_s1_ff <= sclk_pin;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      cs_s1_ff <= cs_n_pin;
      cs_s2_ff <= cs_s1_ff;
      din_s1_ff <= sdio_in;
      din_s2_ff <= din_s1_ff;
    end
  end

  assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
  assign sclk_fall = ~sclk_s2_ff & sclk_s3_ff;
  assign cs_active = ~cs_s2_ff;
  assign restore = setup_ff[RESTORE_BIT];

  // next shift contents; first bit ends up in bit 0 when lsb first
  always_comb begin
    if (order_lsb_ff) begin
      instr_next = {din_s2_ff, instr_sh_ff[15:1]};
      byte_next = {din_s2_ff, data_sh_ff[7:1]};
    end else begin
      instr_next = {instr_sh_ff[14:0], din_s2_ff};
      byte_next = {data_sh_ff[6:0], din_s2_ff};
    end
  end

  assign last_instr = (state_ff == ST_INSTR) && sclk_rise &&
                      (bit_cnt_ff == INSTR_LAST);
  assign last_bit = (state_ff == ST_DATA) && sclk_rise &&
                    (bit_cnt_ff == BYTE_LAST);
  assign more_bytes = stream_ff || (bytes_left_ff != 2'h0);
  assign wr_now = last_bit && !rd_ff;
  assign driving = rd_ff && (state_ff == ST_DATA);

  // frame sequencer; a rising chip select aborts any frame at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      instr_sh_ff <= 16'h0000;
      data_sh_ff <= 8'h00;
      addr_ff <= 13'h0000;
      rd_ff <= 1'b0;
      stream_ff <= 1'b0;
      bytes_left_ff <= 2'h0;
      order_lsb_ff <= 1'b0;
    end else if (!cs_active) begin
      state_ff <= ST_IDLE;
      rd_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // order is frozen per frame so a setup write cannot split it
          state_ff <= ST_INSTR;
          bit_cnt_ff <= 4'h0;
          order_lsb_ff <= setup_ff[LSB_FIRST_BIT];
        end
        ST_INSTR: begin
          if (sclk_rise) begin
            instr_sh_ff <= instr_next;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == INSTR_LAST) begin
              state_ff <= ST_DATA;
              bit_cnt_ff <= 4'h0;
              rd_ff <= instr_next[RW_POS];
              bytes_left_ff <= instr_next[WCNT_HI:WCNT_LO];
              stream_ff <= instr_next[WCNT_HI:WCNT_LO] == WCNT_STREAM;
              addr_ff <= instr_next[12:0];
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            data_sh_ff <= byte_next;
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == BYTE_LAST) begin
              bit_cnt_ff <= 4'h0;
              if (order_lsb_ff) begin
                addr_ff <= addr_ff + 13'h0001;
              end else begin
                addr_ff <= addr_ff - 13'h0001;
              end
              if (!more_bytes) begin
                state_ff <= ST_WAIT;
              end else if (!stream_ff) begin
                bytes_left_ff <= bytes_left_ff - 2'h1;
              end
            end
          end
        end
        ST_WAIT: begin
          state_ff <= ST_WAIT;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // read fetch in the cycle the address settles, load one after that
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ff <= 1'b0;
      fetch_d1_ff <= 1'b0;
    end else begin
      fetch_ff <= (last_instr && instr_next[RW_POS]) ||
                  (last_bit && rd_ff && more_bytes);
      fetch_d1_ff <= fetch_ff;
    end
  end

  // output shifter: loaded between edges, moved on each falling sclk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_ff <= 8'h00;
      out_bit_ff <= 1'b0;
    end else if (fetch_d1_ff) begin
      if (addr_ff == SETUP_ADDR) begin
        out_sh_ff <= setup_ff;
      end else if (addr_ff == READBACK_ADDR) begin
        out_sh_ff <= {7'h00, readback_ff};
      end else if (addr_ff == PDSYNC_ADDR) begin
        out_sh_ff <= mem_rd;
      end else begin
        out_sh_ff <= 8'h00; // spare, transfer and unmapped read 0
      end
    end else if (sclk_fall && driving) begin
      if (order_lsb_ff) begin
        out_bit_ff <= out_sh_ff[0];
        out_sh_ff <= {1'b0, out_sh_ff[7:1]};
      end else begin
        out_bit_ff <= out_sh_ff[7];
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      end
    end
  end

  // setup register stays writable during restore, else it could not end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_ff <= SETUP_RESET;
    end else if (wr_now && addr_ff == SETUP_ADDR) begin
      setup_ff <= byte_next;
    end
  end

  // bank choice takes effect at once, not through the buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readback_ff <= READBACK_RESET[BANK_BIT];
    end else if (restore) begin
      readback_ff <= READBACK_RESET[BANK_BIT];
    end else if (wr_now && addr_ff == READBACK_ADDR) begin
      readback_ff <= byte_next[BANK_BIT];
    end
  end

  // transfer is a pulse only, so the bit is never stored (self-clearing)
  assign xfer_pulse = wr_now && addr_ff == XFER_ADDR &&
                      byte_next[XFER_BIT] && !restore;
  assign mem_wr = wr_now && addr_ff == PDSYNC_ADDR && !restore;

  reg_bank_pair #(
    .ENTRIES(ENTRIES),
    .W(8),
    .RESET_VAL(PDSYNC_RESET),
    .IDX_W(1)
  ) u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .restore(restore),
    .wr_en(mem_wr),
    .wr_idx(1'b0),
    .wr_data(byte_next),
    .xfer(xfer_pulse),
    .rd_idx(1'b0),
    .rd_active(readback_ff),
    .rd_data(mem_rd),
    .active_out(pdsync_active)
  );

  // enables low while driving; the unused pin always floats
  assign sdio_oe_n = ~(driving && !setup_ff[OUTSEL_BIT]);
  assign serial_data_out_oe_n = ~(driving && setup_ff[OUTSEL_BIT]);
  assign sdio_out = out_bit_ff;
  assign serial_data_out_pin = out_bit_ff;
  assign restore_active = restore;
  assign lsb_first_mode = setup_ff[LSB_FIRST_BIT];

  sequence s_active_fetch;
    (fetch_ff && addr_ff == PDSYNC_ADDR && readback_ff && !restore)
      ##1 fetch_d1_ff;
  endsequence

  AST_BIDIR_PIN_USE: assert property (
    @(posedge clk) disable iff (!rst_n)
    driving && !setup_ff[OUTSEL_BIT] |-> !sdio_oe_n && serial_data_out_oe_n)
    else $error("bidirectional mode drove the wrong pin");

  AST_UNIDIR_PIN_USE: assert property (
    @(posedge clk) disable iff (!rst_n)
    driving && setup_ff[OUTSEL_BIT] |-> sdio_oe_n && !serial_data_out_oe_n)
    else $error("unidirectional mode drove the wrong pin");

  AST_ADDR_STEP: assert property (
    @(posedge clk) disable iff (!rst_n)
    last_bit && cs_active |=> addr_ff == (order_lsb_ff ?
      $past(addr_ff) + 13'h0001 : $past(addr_ff) - 13'h0001))
    else $error("address did not step in the bit-order direction");

  AST_OUT_BIT_ORDER: assert property (
    @(posedge clk) disable iff (!rst_n)
    sclk_fall && driving && !fetch_d1_ff |=> out_bit_ff ==
      (order_lsb_ff ? $past(out_sh_ff[0]) : $past(out_sh_ff[7])))
    else $error("read bit left in the wrong order");

  AST_RESTORE_DEFAULTS: assert property (
    @(posedge clk) disable iff (!rst_n)
    restore |=> !readback_ff && pdsync_active == PDSYNC_RESET)
    else $error("restore did not return defaults");

  AST_RESTORE_STICKY: assert property (
    @(posedge clk) disable iff (!rst_n)
    restore && !(wr_now && addr_ff == SETUP_ADDR) |=> restore)
    else $error("restore bit cleared itself");

  AST_READ_ACTIVE_BANK: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_active_fetch |=> out_sh_ff == pdsync_active)
    else $error("active bank not returned on read");

  AST_XFER_READS_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    fetch_d1_ff && addr_ff == XFER_ADDR |=> out_sh_ff == 8'h00)
    else $error("transfer bit did not read back as 0");

endmodule
`default_nettype wire

// >>> sim/host_port_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
  input wire logic clk,
  output logic sclk_pin,
  output logic cs_n_pin,
  output logic sdio_line,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  input wire logic serial_data_out_pin,
  input wire logic serial_data_out_oe_n,
  output logic rd_done,
  output logic [7:0] rd_byte,
  output logic bad
);
  logic host_en, host_bit, idle_bit, lsb, uni;
  logic [7:0] sh;
  wire logic sdo_line;
  initial begin
    {sclk_pin, cs_n_pin, host_en, host_bit, idle_bit} = 5'b01100;
    {rd_done, bad, lsb, uni} = 4'h0;
  end
  // a released line toggles so a stale bit never passes for data
  always @(posedge clk) idle_bit <= ~idle_bit;
  assign sdio_line = !sdio_oe_n ? sdio_out : (host_en ? host_bit : idle_bit);
  assign sdo_line = !serial_data_out_oe_n ? serial_data_out_pin : idle_bit;
  // flags a drive on the pin that the mode leaves floating
  always @(negedge clk) if (uni ? !sdio_oe_n : !serial_data_out_oe_n) bad = 1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // host changes data in the low phase, phases of 8 clocks each
  task automatic put(input logic b);
    sclk_pin <= 1'b0; host_en <= 1'b1; host_bit <= b; tick(8);
    sclk_pin <= 1'b1; tick(8);
  endtask
  task automatic get(output logic b);
    sclk_pin <= 1'b0; host_en <= 1'b0; tick(8);
    b = uni ? sdo_line : sdio_line;
    sclk_pin <= 1'b1; tick(8);
  endtask
  task automatic frame(input logic rd, input int nb, input logic [12:0] a,
      input logic [15:0] wd, input logic lsb_f, input logic uni_f);
    logic [15:0] ins;
    logic b;
    ins = {rd, 2'(nb - 1), a};
    lsb = lsb_f; uni = uni_f; bad = 0;
    cs_n_pin <= 1'b0; tick(3);
    for (int i = 0; i < 16; i++) put(lsb ? ins[i] : ins[15-i]);
    for (int k = 0; k < nb; k++) begin
      for (int i = 0; i < 8; i++) begin
        if (rd) begin
          get(b); sh[lsb ? i : 7-i] = b;
        end else put(lsb ? wd[8*k+i] : wd[8*k+7-i]);
      end
      if (rd) begin
        rd_byte <= sh; rd_done <= 1'b1; tick(1); rd_done <= 1'b0;
      end
    end
    sclk_pin <= 1'b0; host_en <= 1'b1; tick(4);
    cs_n_pin <= 1'b1; tick(6);
  endtask
endmodule
`default_nettype wire

// >>> sim/serial_port_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_config_regs_tb;
  import spcfg_pkg::*;
  logic clk, rst_n, lsb, uni;
  logic sclk, cs_n, sdio, sdo_out, sdio_oe_n, sdo_pin, sdo_oe_n;
  logic restore_active, lsb_first_mode, rd_done, bad;
  logic [7:0] pdsync_active, rd_byte, d1, d2, d3;
  logic [7:0] expq[$];
  int err_total, n_checks;
  serial_port_config_regs i_dut (.clk(clk), .rst_n(rst_n), .sclk_pin(sclk),
    .cs_n_pin(cs_n), .sdio_in(sdio), .sdio_out(sdo_out),
    .sdio_oe_n(sdio_oe_n), .serial_data_out_pin(sdo_pin),
    .serial_data_out_oe_n(sdo_oe_n), .restore_active(restore_active),
    .lsb_first_mode(lsb_first_mode), .pdsync_active(pdsync_active));
  host_port_model host (.clk(clk), .sclk_pin(sclk), .cs_n_pin(cs_n),
    .sdio_line(sdio), .sdio_out(sdo_out), .sdio_oe_n(sdio_oe_n),
    .serial_data_out_pin(sdo_pin), .serial_data_out_oe_n(sdo_oe_n),
    .rd_done(rd_done), .rd_byte(rd_byte), .bad(bad));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // oldest noted byte is matched against each byte the host reads back
  always @(posedge clk) begin
    if (rd_done === 1'b1) begin
      if (expq.size() == 0) chk(rd_byte, 8'hXX);
      else chk(rd_byte, expq.pop_front());
    end
  end
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.frame(1'b0, 1, a, {8'h00, d}, lsb, uni);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.frame(1'b1, 1, a, 16'h0000, lsb, uni);
    chk(bad, 1'b0);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  initial begin
    rst_n = 1'b0; lsb = 0; uni = 0; err_total = 0; n_checks = 0;
    void'($urandom(46));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(pdsync_active, PDSYNC_RESET);
    chk({restore_active, lsb_first_mode, sdio_oe_n, sdo_oe_n}, 8'h03);
    rd(SETUP_ADDR, SETUP_RESET); rd(READBACK_ADDR, READBACK_RESET);
    rd(SPARE_ADDR, 8'h00); rd(XFER_ADDR, 8'h00); rd(13'h0123, 8'h00);
    tend("reset");
    d1 = 8'($urandom()) | 8'h01;
    wr(PDSYNC_ADDR, d1);
    chk(pdsync_active, 8'h00);
    rd(PDSYNC_ADDR, d1);
    wr(READBACK_ADDR, 8'h01);
    rd(PDSYNC_ADDR, 8'h00); rd(READBACK_ADDR, 8'h01);
    wr(XFER_ADDR, 8'h01);
    chk(pdsync_active, d1);
    rd(PDSYNC_ADDR, d1); rd(XFER_ADDR, 8'h00);
    wr(READBACK_ADDR, 8'h00);
    tend("bank");
    // low nibble mirrors high nibble: 5A, 18, 99, 3C
    wr(SETUP_ADDR, 8'h5A); lsb = 1;
    chk(lsb_first_mode, 1'b1);
    d2 = 8'($urandom());
    host.frame(1'b0, 2, 13'h022F, {d2, 8'hFF}, lsb, uni);
    rd(PDSYNC_ADDR, d2);
    wr(SETUP_ADDR, 8'h18); lsb = 0;
    d3 = 8'($urandom()) | 8'h80;
    host.frame(1'b0, 2, SPARE_ADDR, {d3, 8'hEE}, lsb, uni);
    expq.push_back(8'h00); expq.push_back(d3);
    host.frame(1'b1, 2, SPARE_ADDR, 16'h0000, lsb, uni);
    tend("order");
    wr(SETUP_ADDR, 8'h99); uni = 1;
    rd(PDSYNC_ADDR, d3);
    wr(SETUP_ADDR, 8'h18); uni = 0;
    rd(SETUP_ADDR, 8'h18);
    tend("pins");
    wr(READBACK_ADDR, 8'h01);
    wr(SETUP_ADDR, 8'h3C);
    chk(8'(restore_active), 8'h01);
    chk(pdsync_active, PDSYNC_RESET);
    wr(PDSYNC_ADDR, 8'h55); wr(XFER_ADDR, 8'h01);
    rd(PDSYNC_ADDR, 8'h00); rd(SETUP_ADDR, 8'h3C);
    chk(8'(restore_active), 8'h01);
    chk(pdsync_active, PDSYNC_RESET);
    wr(SETUP_ADDR, 8'h18);
    chk(restore_active, 1'b0);
    rd(READBACK_ADDR, 8'h00); rd(PDSYNC_ADDR, 8'h00);
    chk(pdsync_active, 8'h00);
    tend("restore");
    for (int i = 0; i < 100 && expq.size() != 0; i++) @(posedge clk);
    if (expq.size() != 0) chk(8'(expq.size()), 8'h00);
    results();
  end
endmodule
`default_nettype wire
